//--- logic/spc_pkg.sv
// Shared constants and types for the strap pin configuration loader
package spc_pkg;

    // Timing
    localparam int CLK_MHZ = 125;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS * CLK_MHZ) / 1000;
    localparam int SETTLE_US = 4;
    localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_US - 1);

    // Strap pins, in scan order
    localparam int NUM_STRAPS = 4;
    localparam logic [1:0] PIN_REF = 2'h0;
    localparam logic [1:0] PIN_AUX = 2'h1;
    localparam logic [1:0] PIN_HI = 2'h2;
    localparam logic [1:0] PIN_LO = 2'h3;

    // Register map (byte addresses)
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_STRAPS = 8'h08;
    localparam logic [7:0] ADR_CFG0 = 8'h0C;
    localparam logic [7:0] ADR_CFG1 = 8'h10;
    localparam int CTRL_RESCAN_BIT = 0;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_VALID_BIT = 1;
    localparam int STAT_INTPD_BIT = 2;

    // Reference receiver types
    localparam logic [1:0] REF_XTAL = 2'h0;
    localparam logic [1:0] REF_CMOS = 2'h1;
    localparam logic [1:0] REF_DIFF = 2'h2;

    // Output frequency codes
    localparam logic [3:0] F_OFF = 4'h0;
    localparam logic [3:0] F25 = 4'h1;
    localparam logic [3:0] F50 = 4'h2;
    localparam logic [3:0] F100 = 4'h3;
    localparam logic [3:0] F125 = 4'h4;
    localparam logic [3:0] F156 = 4'h5;
    localparam logic [3:0] F312 = 4'h6;
    localparam logic [3:0] F625 = 4'h7;
    localparam logic [3:0] F400 = 4'h8;
    localparam logic [3:0] F33 = 4'h9;
    localparam logic [3:0] F70 = 4'hA;
    localparam logic [3:0] F24 = 4'hB;

    // Output driver formats
    localparam logic [2:0] FM_OFF = 3'h0;
    localparam logic [2:0] HS = 3'h1;
    localparam logic [2:0] LV = 3'h2;
    localparam logic [2:0] CM = 3'h3;
    localparam logic [2:0] HC = 3'h4;

    // Shared pair source
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_FRAC = 2'h1;
    localparam logic [1:0] SRC_IOUT = 2'h2;
    localparam logic [1:0] SRC_IREF = 2'h3;

    typedef struct packed {
        logic [3:0] freq;
        logic [2:0] fmt;
    } spc_grp_t;

    typedef struct packed {
        logic [3:0] ref_freq;
        spc_grp_t [3:0] grp;
        logic [1:0] pair_src;
    } spc_preset_t;

    typedef struct packed {
        logic [1:0] prim_ref;
        logic sec_xtal;
        logic int_ref_sel;
        logic frac_dbl_en;
        logic int_dbl_en;
        logic [2:0] aux_state;
        logic aux_lvds;
        logic aux_from_pll;
        spc_preset_t preset;
        logic pair_src_sel;
        logic main_en;
        logic int_pll_pd;
    } spc_cfg_t;

    typedef enum logic [2:0] {ST_IDLE, ST_SETTLE, ST_SAMPLE, ST_LOOKUP, ST_LATCH} spc_fsm_t;

    typedef struct packed {
        spc_fsm_t fsm;
        logic busy;
        logic [1:0] pin;
        logic [2:0] cnt;
        logic [NUM_STRAPS-1:0][2:0] codes;
        logic scan_req;
        logic ext_q;
        logic valid;
        spc_cfg_t cfg;
        logic ack;
        logic [31:0] dat;
    } spc_main_t;

    localparam spc_cfg_t CFG_RST = '{int_pll_pd: 1'b1, default: '0};
    localparam spc_main_t MAIN_RST = '{fsm: ST_SETTLE, busy: 1'b1, cfg: CFG_RST, default: '0};

endpackage

//--- logic/spc_tick_div.sv
// Divider that makes a one-cycle microsecond tick
`timescale 1ns/100ps
`default_nettype none
module spc_tick_div import spc_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    output logic tick_o     // One-cycle pulse every TICK_CYC cycles
);
    localparam int CW = $clog2(TICK_CYC);
    localparam logic [CW-1:0] LAST = CW'(TICK_CYC - 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } spc_div_t;

    spc_div_t st_r;
    spc_div_t st_nxt;

    always_comb begin
        st_nxt.tick = (st_r.cnt == LAST);
        st_nxt.cnt = st_nxt.tick ? '0 : st_r.cnt + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick_o = st_r.tick;
endmodule
`default_nettype wire

//--- logic/spc_preset_rom.sv
// Translation preset table, registered read
`timescale 1ns/100ps
`default_nettype none
module spc_preset_rom import spc_pkg::*; (
    input wire logic clk_i,        // System clock
    input wire logic rst_i,        // Synchronous reset, active high
    input wire logic [5:0] addr_i, // {upper strap, lower strap}
    output spc_preset_t data_o     // Preset, one cycle after addr_i
);
    spc_preset_t data_r;
    spc_preset_t data_nxt;

    function automatic spc_preset_t mk(input logic [3:0] f0, input logic [2:0] m0, input logic [3:0] f1,
                                       input logic [2:0] m1, input logic [3:0] f2, input logic [2:0] m2,
                                       input logic [3:0] f3, input logic [2:0] m3, input logic [1:0] src);
        spc_preset_t p;
        p.ref_freq = F25;
        p.grp[0] = '{freq: f0, fmt: m0};
        p.grp[1] = '{freq: f1, fmt: m1};
        p.grp[2] = '{freq: f2, fmt: m2};
        p.grp[3] = '{freq: f3, fmt: m3};
        p.pair_src = src;
        return p;
    endfunction

    // Combinations not listed leave every main output off
    always_comb begin
        data_nxt = mk(F_OFF, FM_OFF, F_OFF, FM_OFF, F_OFF, FM_OFF, F_OFF, FM_OFF, SRC_NONE);
        case (addr_i)
            6'h01: data_nxt = mk(F156, HS, F156, HS, F156, HS, F156, HS, SRC_FRAC);
            6'h02: data_nxt = mk(F156, LV, F156, LV, F156, LV, F156, LV, SRC_FRAC);
            6'h03: data_nxt = mk(F156, HS, F156, HS, F100, HS, F25, CM, SRC_IREF);
            6'h04: data_nxt = mk(F156, LV, F156, LV, F100, HS, F25, CM, SRC_IREF);
            6'h05: data_nxt = mk(F156, HS, F125, HS, F100, HS, F50, CM, SRC_IOUT);
            6'h06: data_nxt = mk(F156, HS, F125, HS, F100, HS, F25, CM, SRC_IREF);
            6'h07: data_nxt = mk(F156, LV, F125, LV, F100, HS, F25, CM, SRC_IREF);
            6'h08: data_nxt = mk(F156, LV, F125, LV, F25, HS, F25, CM, SRC_IREF);
            6'h09: data_nxt = mk(F156, HS, F125, HS, F25, HS, F25, CM, SRC_IREF);
            6'h0A: data_nxt = mk(F156, HS, F100, HS, F50, HS, F125, HS, SRC_FRAC);
            6'h0B: data_nxt = mk(F156, LV, F100, LV, F50, HS, F125, HS, SRC_FRAC);
            6'h0C: data_nxt = mk(F156, LV, F100, LV, F100, LV, F25, CM, SRC_IREF);
            6'h0D: data_nxt = mk(F156, HS, F100, HS, F25, HS, F25, CM, SRC_IREF);
            6'h0E: data_nxt = mk(F156, LV, F100, LV, F25, HS, F25, CM, SRC_IREF);
            6'h0F: data_nxt = mk(F156, HS, F100, HS, F125, HS, F312, HS, SRC_FRAC);
            6'h10: data_nxt = mk(F156, LV, F100, LV, F125, LV, F312, LV, SRC_FRAC);
            6'h11: data_nxt = mk(F156, HS, F312, HS, F125, HS, F25, HS, SRC_IREF);
            6'h12: data_nxt = mk(F156, LV, F312, LV, F125, LV, F25, LV, SRC_IREF);
            6'h13: data_nxt = mk(F312, HS, F100, HS, F100, HS, F156, HS, SRC_FRAC);
            6'h14: data_nxt = mk(F312, LV, F100, LV, F100, LV, F156, LV, SRC_FRAC);
            6'h15: data_nxt = mk(F312, HS, F100, HS, F125, HS, F156, HS, SRC_FRAC);
            6'h16: data_nxt = mk(F312, LV, F100, LV, F125, LV, F156, LV, SRC_FRAC);
            6'h17: data_nxt = mk(F312, HS, F100, HS, F156, HS, F156, HS, SRC_FRAC);
            6'h18: data_nxt = mk(F312, LV, F100, LV, F156, LV, F156, LV, SRC_FRAC);
            6'h19: data_nxt = mk(F625, HS, F100, LV, F100, LV, F156, HS, SRC_FRAC);
            6'h1A: data_nxt = mk(F100, HS, F312, HS, F156, HS, F125, HS, SRC_FRAC);
            6'h1B: data_nxt = mk(F100, LV, F312, LV, F156, LV, F125, LV, SRC_FRAC);
            6'h1C: data_nxt = mk(F100, HS, F312, HS, F156, HS, F25, HS, SRC_IREF);
            6'h1D: data_nxt = mk(F100, LV, F312, LV, F156, LV, F25, LV, SRC_IREF);
            6'h1E: data_nxt = mk(F100, HS, F100, HS, F100, HS, F100, HC, SRC_FRAC);
            6'h1F: data_nxt = mk(F100, LV, F100, LV, F100, LV, F100, HC, SRC_FRAC);
            6'h20: data_nxt = mk(F125, HS, F125, HS, F125, HS, F125, HS, SRC_FRAC);
            6'h21: data_nxt = mk(F125, LV, F125, LV, F125, LV, F125, LV, SRC_FRAC);
            6'h22: data_nxt = mk(F125, HS, F100, HS, F100, HS, F33, HS, SRC_IOUT);
            6'h23: data_nxt = mk(F125, LV, F100, LV, F100, LV, F33, LV, SRC_IOUT);
            6'h24: data_nxt = mk(F125, HS, F100, HS, F25, HS, F25, HS, SRC_IREF);
            6'h25: data_nxt = mk(F125, LV, F100, LV, F25, LV, F25, LV, SRC_IREF);
            6'h26: data_nxt = mk(F25, LV, F25, LV, F125, LV, F100, HC, SRC_FRAC);
            6'h27: data_nxt = mk(F100, LV, F100, LV, F125, HS, F25, CM, SRC_IREF);
            6'h28: data_nxt = mk(F100, HS, F100, HS, F125, HS, F25, CM, SRC_IREF);
            6'h29: data_nxt = mk(F156, HS, F50, HS, F125, HS, F25, CM, SRC_IREF);
            6'h2A: data_nxt = mk(F156, LV, F50, LV, F125, LV, F25, CM, SRC_IREF);
            6'h2B: data_nxt = mk(F100, HS, F100, HS, F100, HS, F100, HC, SRC_IOUT);
            6'h2C: data_nxt = mk(F100, LV, F100, LV, F100, LV, F100, HC, SRC_IOUT);
            6'h2D: data_nxt = mk(F25, HS, F25, HS, F25, HS, F400, LV, SRC_IOUT);
            6'h2E: data_nxt = mk(F156, HS, F50, HS, F125, HS, F400, HC, SRC_IOUT);
            6'h2F: data_nxt = mk(F156, LV, F50, LV, F125, LV, F400, HC, SRC_IOUT);
            6'h30: data_nxt = mk(F70, HS, F70, HS, F70, HS, F25, HS, SRC_IREF);
            6'h31: data_nxt = mk(F24, HS, F24, HS, F24, HS, F100, HC, SRC_IOUT);
            6'h32: data_nxt = mk(F24, LV, F24, LV, F24, LV, F100, HC, SRC_IOUT);
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_r <= '0;
        end else begin
            data_r <= data_nxt;
        end
    end

    assign data_o = data_r;
endmodule
`default_nettype wire

//--- logic/spc_strap_cfg.sv
// Strap pin scanner and power-on configuration decoder with Wishbone status access
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Scan all straps after power-on reset and on each external reset assertion.
// - Four strap pins, each resolved per scan to one 3-bit state of eight.
// - Each block's configuration comes only from its own strap's scanned state, except integer PLL power-down, which uses straps 1-3.
// - Strap 0 inputs and doublers, strap 1 aux output, straps 2-3 translation.
// - Primary receiver xtal/CMOS/differential by state; secondary xtal only in 4 and 6.
// - Integer PLL source: states 0-3 fractional active ref, 4-7 secondary ref.
// - Fractional doubler off in states 2,3 else on; integer doubler always off.
// - Aux output: state 0 reference CMOS, 1-3 PLL CMOS, 4-7 PLL LVDS.
// - Translation strap pair selects one of 50 presets; 0/0 disables main outputs.
// - Pair source select: 0 channel divider, 1 integer PLL active reference.
// - Power down integer PLL when no upper driver uses its output.
module spc_strap_cfg import spc_pkg::*; (
    input wire logic clk_i,             // 125 MHz system clock
    input wire logic rst_i,             // Synchronous chip reset, active high
    input wire logic ext_reset_i,       // External reset pin level, active high
    output logic [1:0] scan_sel_o,      // Strap pin now being scanned
    output logic scan_req_o,            // Level: asks the scanner for a reading
    input wire logic scan_done_i,       // One-cycle pulse: scan_code_i is valid
    input wire logic [2:0] scan_code_i, // Resolved strap state
    output spc_cfg_t cfg_o,             // Latched power-on configuration
    output logic cfg_valid_o,           // Configuration latched by a finished scan
    output logic scan_busy_o,           // Scan in progress
    input wire logic wb_cyc_i,          // Wishbone cycle
    input wire logic wb_stb_i,          // Wishbone strobe
    input wire logic wb_we_i,           // Wishbone write enable
    input wire logic [7:0] wb_adr_i,    // Wishbone byte address
    input wire logic [3:0] wb_sel_i,    // Wishbone byte selects
    input wire logic [31:0] wb_dat_i,   // Wishbone write data
    output logic [31:0] wb_dat_o,       // Wishbone read data
    output logic wb_ack_o               // Wishbone acknowledge
);
    spc_main_t st_r;
    spc_main_t st_nxt;
    spc_preset_t rom_q;
    logic tick;
    logic hit;
    logic rescan;
    logic start;
    logic [63:0] cfg_wide;

    spc_tick_div u_tick (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_o(tick)
    );

    spc_preset_rom u_rom (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .addr_i({st_r.codes[PIN_HI], st_r.codes[PIN_LO]}),
        .data_o(rom_q)
    );

    function automatic logic [1:0] prim_ref_of(input logic [2:0] s);
        unique case (s)
            3'h0, 3'h4: return REF_XTAL;
            3'h1, 3'h2, 3'h5: return REF_CMOS;
            3'h3, 3'h6, 3'h7: return REF_DIFF;
        endcase
    endfunction

    function automatic logic sec_xtal_of(input logic [2:0] s);
        return (s == 3'h4) || (s == 3'h6);
    endfunction

    function automatic logic frac_dbl_of(input logic [2:0] s);
        return (s != 3'h2) && (s != 3'h3);
    endfunction

    always_comb begin
        hit = wb_cyc_i && wb_stb_i && !st_r.ack;
        rescan = hit && wb_we_i && wb_sel_i[0] && (wb_adr_i == ADR_CTRL) && wb_dat_i[CTRL_RESCAN_BIT];
        start = (ext_reset_i && !st_r.ext_q) || rescan;
        cfg_wide = 64'(st_r.cfg);
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.ext_q = ext_reset_i;
        st_nxt.ack = hit;
        unique case (st_r.fsm)
            ST_IDLE: begin
            end
            ST_SETTLE: begin
                // Lets the scanner's sense node settle after switching pins
                if (tick) begin
                    if (st_r.cnt == SETTLE_LAST) begin
                        st_nxt.cnt = '0;
                        st_nxt.scan_req = 1'b1;
                        st_nxt.fsm = ST_SAMPLE;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 3'h1;
                    end
                end
            end
            ST_SAMPLE: begin
                if (scan_done_i) begin
                    st_nxt.codes[st_r.pin] = scan_code_i;
                    st_nxt.scan_req = 1'b0;
                    if (st_r.pin == PIN_LO) begin
                        st_nxt.fsm = ST_LOOKUP;
                    end else begin
                        st_nxt.pin = st_r.pin + 2'h1;
                        st_nxt.fsm = ST_SETTLE;
                    end
                end
            end
            ST_LOOKUP: begin
                st_nxt.fsm = ST_LATCH;
            end
            ST_LATCH: begin
                // Each field reads only the strap that owns it, except int_pll_pd, which reads the aux strap and the preset
                st_nxt.cfg.prim_ref = prim_ref_of(st_r.codes[PIN_REF]);
                st_nxt.cfg.sec_xtal = sec_xtal_of(st_r.codes[PIN_REF]);
                st_nxt.cfg.int_ref_sel = st_r.codes[PIN_REF][2];
                st_nxt.cfg.frac_dbl_en = frac_dbl_of(st_r.codes[PIN_REF]);
                st_nxt.cfg.int_dbl_en = 1'b0;
                st_nxt.cfg.aux_state = st_r.codes[PIN_AUX];
                st_nxt.cfg.aux_lvds = st_r.codes[PIN_AUX][2];
                st_nxt.cfg.aux_from_pll = (st_r.codes[PIN_AUX] != 3'h0);
                st_nxt.cfg.preset = rom_q;
                st_nxt.cfg.pair_src_sel = (rom_q.pair_src == SRC_IREF);
                st_nxt.cfg.main_en = (st_r.codes[PIN_HI] != 3'h0) || (st_r.codes[PIN_LO] != 3'h0);
                st_nxt.cfg.int_pll_pd = !((st_r.codes[PIN_AUX] != 3'h0) || (rom_q.pair_src == SRC_IOUT));
                st_nxt.valid = 1'b1;
                st_nxt.fsm = ST_IDLE;
            end
        endcase
        // A new trigger restarts the scan at once; the old settings stay in force meanwhile
        if (start) begin
            st_nxt.fsm = ST_SETTLE;
            st_nxt.pin = PIN_REF;
            st_nxt.cnt = '0;
            st_nxt.scan_req = 1'b0;
            st_nxt.valid = 1'b0;
        end
        if (hit && !wb_we_i) begin
            unique case (wb_adr_i)
                ADR_STATUS: begin
                    st_nxt.dat = '0;
                    st_nxt.dat[STAT_BUSY_BIT] = (st_r.fsm != ST_IDLE);
                    st_nxt.dat[STAT_VALID_BIT] = st_r.valid;
                    st_nxt.dat[STAT_INTPD_BIT] = st_r.cfg.int_pll_pd;
                end
                ADR_STRAPS: st_nxt.dat = 32'(st_r.codes);
                ADR_CFG0: st_nxt.dat = cfg_wide[31:0];
                ADR_CFG1: st_nxt.dat = cfg_wide[63:32];
                default: st_nxt.dat = 32'h0000_0000;
            endcase
        end else if (hit) begin
            st_nxt.dat = 32'h0000_0000;
        end
        // Kept in a flop so the pin never glitches while the state decodes
        st_nxt.busy = (st_nxt.fsm != ST_IDLE);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= MAIN_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign scan_sel_o = st_r.pin;
    assign scan_req_o = st_r.scan_req;
    assign cfg_o = st_r.cfg;
    assign cfg_valid_o = st_r.valid;
    assign scan_busy_o = st_r.busy;
    assign wb_dat_o = st_r.dat;
    assign wb_ack_o = st_r.ack;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_POR_SCAN: assert property ($past(rst_i) |-> st_r.fsm == ST_SETTLE && st_r.pin == PIN_REF)
        else $error("scan did not start after reset");

    AST_EXT_SCAN: assert property (ext_reset_i && !st_r.ext_q |=> st_r.fsm == ST_SETTLE && !st_r.valid
        && st_r.pin == PIN_REF && st_r.cnt == 3'h0)
        else $error("external reset did not restart scan");

    AST_CODE_CAPTURE: assert property (st_r.fsm == ST_SAMPLE && scan_done_i && !start
        |=> st_r.codes[$past(st_r.pin)] == $past(scan_code_i) && !st_r.scan_req)
        else $error("strap code not captured");

    AST_SCAN_LENGTH: assert property (st_r.fsm == ST_SAMPLE && scan_done_i && st_r.pin == PIN_LO && !start
        |=> st_r.fsm == ST_LOOKUP ##1 st_r.fsm == ST_LATCH ##1 st_r.valid)
        else $error("scan did not finish after last pin");

    AST_REF_RX: assert property ($rose(st_r.valid) |-> st_r.cfg.sec_xtal == sec_xtal_of(st_r.codes[PIN_REF])
        && (st_r.cfg.prim_ref == REF_XTAL) == (st_r.codes[PIN_REF] == 3'h0 || st_r.codes[PIN_REF] == 3'h4))
        else $error("reference receiver decode wrong");

    AST_INT_SRC: assert property ($rose(st_r.valid) |-> st_r.cfg.int_ref_sel == (st_r.codes[PIN_REF] > 3'h3))
        else $error("integer PLL source decode wrong");

    AST_DOUBLERS: assert property ($rose(st_r.valid) |-> !st_r.cfg.int_dbl_en
        && st_r.cfg.frac_dbl_en == !(st_r.codes[PIN_REF] inside {3'h2, 3'h3}))
        else $error("doubler decode wrong");

    AST_AUX_OUT: assert property ($rose(st_r.valid) |-> st_r.cfg.aux_lvds == (st_r.codes[PIN_AUX] >= 3'h4)
        && st_r.cfg.aux_from_pll == (st_r.codes[PIN_AUX] != 3'h0) && st_r.cfg.aux_state == st_r.codes[PIN_AUX])
        else $error("aux output decode wrong");

    AST_MAIN_OFF: assert property ($rose(st_r.valid) && st_r.codes[PIN_HI] == 3'h0 && st_r.codes[PIN_LO] == 3'h0
        |-> !st_r.cfg.main_en && st_r.cfg.preset.pair_src == SRC_NONE)
        else $error("preset 0/0 left outputs on");

    AST_PAIR_SRC: assert property (st_r.cfg.pair_src_sel == (st_r.cfg.preset.pair_src == SRC_IREF))
        else $error("pair source select mismatch");

    AST_INT_PD: assert property (st_r.cfg.int_pll_pd
        == !(st_r.cfg.aux_from_pll || st_r.cfg.preset.pair_src == SRC_IOUT))
        else $error("integer PLL power-down wrong");

    AST_HOLD: assert property (st_r.fsm != ST_LATCH |=> $stable(st_r.cfg))
        else $error("configuration changed outside latch");

    AST_BUSY_FLAG: assert property (st_r.busy == (st_r.fsm != ST_IDLE))
        else $error("busy flag out of step with scan state");

    COV_SCAN_DONE: cover property ($rose(st_r.valid));
    COV_EXT_RESCAN: cover property (ext_reset_i && !st_r.ext_q && st_r.valid);
    COV_INT_PD: cover property ($rose(st_r.valid) && !st_r.cfg.int_pll_pd);
    COV_STATUS_READ: cover property (hit && !wb_we_i && wb_adr_i == ADR_STATUS);
endmodule
`default_nettype wire

//--- verification/spc_strap_model.sv
// Strap resistors plus level scanner seen from the loader's scanner port
`timescale 1ns/100ps
`default_nettype none
module spc_strap_model import spc_pkg::*; (
    input wire logic clk_i, // System clock
    input wire logic rst_i, // Synchronous reset, active high
    input wire logic [1:0] sel_i, // Strap being scanned
    input wire logic req_i, // Reading requested
    input wire logic [NUM_STRAPS-1:0][2:0] straps_i, // Board strap states
    input wire logic [7:0] lag_i, // Cycles of request before answering
    output logic done_o, // One-cycle answer pulse
    output logic [2:0] code_o // Resolved state, valid with done_o
);
    logic [7:0] wait_r;
    logic [2:0] last_r;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        // Outside the answer the code lines carry junk, not the old reading
        code_o <= ~last_r;
        if (rst_i) begin
            wait_r <= '0;
            last_r <= '0;
        end else if (req_i && !done_o) begin
            if (wait_r >= lag_i) begin
                done_o <= 1'b1;
                code_o <= straps_i[sel_i];
                last_r <= straps_i[sel_i];
                wait_r <= '0;
            end else begin
                wait_r <= wait_r + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/spc_strap_cfg_bench.sv
// Self-checking bench for the strap configuration loader
`timescale 1ns/100ps
`default_nettype none
module spc_strap_cfg_bench import spc_pkg::*;;
    logic clk_i = 0, rst_i = 1, ext_reset_i = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0] wb_adr_i = '0, lag = '0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
    logic [1:0] scan_sel_o;
    logic scan_req_o, scan_done_i, cfg_valid_o, scan_busy_o, wb_ack_o;
    logic [2:0] scan_code_i, r, a, h, l;
    logic [NUM_STRAPS-1:0][2:0] straps = '0;
    spc_cfg_t cfg_o, held = CFG_RST;
    int errors = 0, check_count = 0, cycles = 0;
    logic [5:0] cmb [4] = '{6'h00, 6'h01, 6'h03, 6'h2D};
    spc_preset_t pre [4] = '{{F25, F_OFF, FM_OFF, F_OFF, FM_OFF, F_OFF, FM_OFF, F_OFF, FM_OFF, SRC_NONE},
        {F25, F156, HS, F156, HS, F156, HS, F156, HS, SRC_FRAC}, {F25, F25, CM, F100, HS, F156, HS, F156, HS, SRC_IREF},
        {F25, F400, LV, F25, HS, F25, HS, F25, HS, SRC_IOUT}};

    spc_strap_cfg dut_u (.clk_i, .rst_i, .ext_reset_i, .scan_sel_o, .scan_req_o, .scan_done_i, .scan_code_i,
        .cfg_o, .cfg_valid_o, .scan_busy_o, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    spc_strap_model model_u (.clk_i, .rst_i, .sel_i(scan_sel_o), .req_i(scan_req_o), .straps_i(straps),
        .lag_i(lag), .done_o(scan_done_i), .code_o(scan_code_i));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic wrap_up;
        if (errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Eight scans take about 20000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            errors++;
            wrap_up();
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic pulse;
        @(posedge clk_i);
        ext_reset_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        ext_reset_i <= 1'b0;
    endtask

    function automatic logic [10:0] front(input logic [2:0] rs, input logic [2:0] as);
        logic [1:0] p;
        p = (rs == 0 || rs == 4) ? REF_XTAL : (rs == 1 || rs == 2 || rs == 5) ? REF_CMOS : REF_DIFF;
        return {p, rs == 4 || rs == 6, rs[2], !(rs == 2 || rs == 3), 1'b0, as, as[2], as != 0};
    endfunction

    initial begin
        void'($urandom(32'h2C1D));
        repeat (6) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            r = 3'(i);
            a = 3'(7 - i);
            {h, l} = i < 4 ? cmb[i] : 6'($urandom);
            // Every preset runs the primaries at 25 MHz, so any reference strap is legal
            straps <= {l, h, a, r};
            lag <= 8'($urandom_range(40));
            if (i == 0) rst_i <= 1'b0;
            else if (i % 2 == 1) wb(1'b1, ADR_CTRL, 32'h1);
            else if (i == 6) begin
                // Chip reset in mid-run also wipes the held settings
                rst_i <= 1'b1;
                repeat (2) @(posedge clk_i);
                rst_i <= 1'b0;
                held = CFG_RST;
            end else pulse();
            repeat (600) @(posedge clk_i);
            chk(cfg_valid_o, 1'b0);
            chk(scan_busy_o, 1'b1);
            chk(cfg_o, held);
            if (i == 5) begin
                repeat (900) @(posedge clk_i);
                {r, a} = 6'h08;
                straps <= {l, h, a, r};
                pulse();
            end
            repeat (2) @(posedge clk_i);
            while (cfg_valid_o !== 1'b1) @(posedge clk_i);
            chk(cfg_o[47:37], front(r, a));
            chk(cfg_o.main_en, {h, l} != 0);
            if (i < 4) begin
                chk(cfg_o.preset, pre[i]);
                chk({cfg_o.pair_src_sel, cfg_o.int_pll_pd}, {pre[i].pair_src == SRC_IREF, a == 0 && pre[i].pair_src != SRC_IOUT});
            end
            wb(1'b0, ADR_STRAPS, 32'h0);
            chk(rd, {20'h0, l, h, a, r});
            wb(1'b0, ADR_STATUS, 32'h0);
            chk(rd, {29'h0, cfg_o.int_pll_pd, 2'b10});
            held = cfg_o;
            straps <= ~straps;
            repeat (50) @(posedge clk_i);
            chk(cfg_o, held);
        end
        wb(1'b1, 8'hFC, 32'hFFFFFFFF);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        chk(scan_busy_o, 1'b0);
        wb(1'b0, ADR_CFG1, 32'h0);
        chk(rd, {16'h0, held[47:32]});
        wb(1'b0, ADR_CFG0, 32'h0);
        chk(rd, held[31:0]);
        wrap_up();
    end
endmodule
`default_nettype wire
